// ### fkl_pkg.sv
// Summary of operation
// - key setting offers eleven choices, disabled to item cycling
// - setting defaults to run_reset_toggle after configuration reset
// - reset action needs key held continuously two seconds
// - run action needs key held one second
// - every other action fires after a one second hold
// - item cycling steps through five monitor items per qualified press
// - key ignored unless key protect is off
// - either autotune toggle cancels any running autotune
// - partial autotune accepted but inert under heat/cool or floating
// - release clears alarms 1-3, burnout, short and overcurrent latches
// - hold toggle alternates hold and hold cleared
// - two front keys together act as the function key when has_function_key is low
// - latched overcurrent holds until max threshold, power or release
// - latched overcurrent forced off on entering setup levels
// - overcurrent latch enable defaults disabled
// - overcurrent use defaults enabled
// - overcurrent hysteresis 0.1 to 50.0 A, default 0.1
// - hysteresis applies only with use on and latch off
// - cooling coefficient found by heat/cool autotune, default off
package fkl_pkg;
  // ****************
  // settings
  // ****************
  typedef enum logic [3:0] {
    FKL_OFF = 4'h0, FKL_RUN = 4'h1, FKL_RST = 4'h2, FKL_RUN_RST = 4'h3,
    FKL_HOLD = 4'h4, FKL_STEP = 4'h5, FKL_AT_FULL = 4'h6,
    FKL_AT_PART = 4'h7, FKL_ALM_REL = 4'h8, FKL_AUTO_MAN = 4'h9,
    FKL_ITEM = 4'ha
  } fkl_setting_t;
  localparam fkl_setting_t SETTING_RST = FKL_RUN_RST;
  localparam logic LATCH_EN_RST = 1'b0;
  localparam logic OC_USE_RST = 1'b1;
  localparam logic COOL_ADJ_RST = 1'b0;
  // hysteresis in tenths of an ampere
  localparam logic [9:0] HYST_MIN = 10'h001;
  localparam logic [9:0] HYST_MAX = 10'h1f4;
  localparam logic [9:0] HYST_RST = 10'h001;
  localparam logic [9:0] OC_THR_MAX = 10'h1f4;
  localparam logic [2:0] ITEM_COUNT = 3'h5;
  // ****************
  // register map
  // ****************
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_HYST = 4'h1;
  localparam logic [3:0] ADDR_THR = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  localparam int CFG_SET_LSB = 0;
  localparam int CFG_PROT = 4;
  localparam int CFG_LATCH = 5;
  localparam int CFG_USE = 6;
  localparam int CFG_COOL = 7;
  localparam int CFG_HC = 8;
  // ****************
  // timing
  // ****************
  localparam int CLK_HZ = 40000000;
  localparam int HOLD_RUN_MS = 1000;
  localparam int HOLD_RST_MS = 2000;
  localparam int HOLD_RUN_CYC = CLK_HZ / 1000 * HOLD_RUN_MS;
  localparam int HOLD_RST_CYC = CLK_HZ / 1000 * HOLD_RST_MS;
  typedef enum logic [1:0] {
    FKL_IDLE = 2'b00, FKL_TIMING = 2'b01, FKL_WAIT_REL = 2'b11
  } fkl_state_t;
endpackage : fkl_pkg

// ### fkl_function_key.sv
`timescale 1ns/100ps
module fkl_function_key #(
  parameter int HOLD_RUN_CYC = fkl_pkg::HOLD_RUN_CYC,
  parameter int HOLD_RST_CYC = fkl_pkg::HOLD_RST_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic function_key,
  input wire logic front_key_a,
  input wire logic front_key_b,
  input wire logic has_function_key,
  input wire logic floating_ctrl,
  input wire logic oc_raw,
  input wire logic [2:0] alarm_raw,
  input wire logic burnout_raw,
  input wire logic heater_short_alarm_raw,
  input wire logic event_release,
  input wire logic setup_level,
  input wire logic [9:0] oc_current,
  output logic run_pulse,
  output logic reset_pulse,
  output logic run_state,
  output logic hold_state,
  output logic step_forward_pulse,
  output logic autotune_full,
  output logic autotune_partial,
  output logic auto_manual,
  output logic [2:0] item_sel,
  output logic cool_coef_calc,
  output logic [2:0] alarm_out,
  output logic burnout_out,
  output logic heater_short_alarm_out,
  output logic oc_out
);
  // ****************
  // configuration registers
  // ****************
  logic [3:0] setting_reg;
  logic protect_reg, latch_en_reg, oc_use_reg, cool_adj_reg, heat_cool_reg;
  logic [9:0] hyst_reg, thr_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      setting_reg <= fkl_pkg::SETTING_RST;
      protect_reg <= 1'b0;
      latch_en_reg <= fkl_pkg::LATCH_EN_RST;
      oc_use_reg <= fkl_pkg::OC_USE_RST;
      cool_adj_reg <= fkl_pkg::COOL_ADJ_RST;
      heat_cool_reg <= 1'b0;
    end else if (wr && addr == fkl_pkg::ADDR_CFG) begin
      // out of range settings are refused, old value kept
      if (wdata[3:0] <= 4'(fkl_pkg::FKL_ITEM)) begin
        setting_reg <= wdata[3:0];
      end
      protect_reg <= wdata[fkl_pkg::CFG_PROT];
      latch_en_reg <= wdata[fkl_pkg::CFG_LATCH];
      oc_use_reg <= wdata[fkl_pkg::CFG_USE];
      cool_adj_reg <= wdata[fkl_pkg::CFG_COOL];
      heat_cool_reg <= wdata[fkl_pkg::CFG_HC];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hyst_reg <= fkl_pkg::HYST_RST;
    end else if (wr && addr == fkl_pkg::ADDR_HYST) begin
      if (wdata[9:0] >= fkl_pkg::HYST_MIN &&
          wdata[9:0] <= fkl_pkg::HYST_MAX) begin
        hyst_reg <= wdata[9:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thr_reg <= fkl_pkg::OC_THR_MAX;
    end else if (wr && addr == fkl_pkg::ADDR_THR) begin
      thr_reg <= (wdata[9:0] > fkl_pkg::OC_THR_MAX) ?
                 fkl_pkg::OC_THR_MAX : wdata[9:0];
    end
  end
  // ****************
  // key input synchroniser
  // ****************
  logic key_raw;
  logic [2:0] key_sync_reg;
  logic key_reg;
  // variant without a dedicated key uses two front keys together
  assign key_raw = has_function_key ? function_key :
                   (front_key_a & front_key_b);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_sync_reg <= 3'h0;
    end else begin
      key_sync_reg <= {key_sync_reg[1:0], key_raw};
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_reg <= 1'b0;
    end else if (key_sync_reg[1] == key_sync_reg[2]) begin
      key_reg <= key_sync_reg[2];
    end
  end
  // ****************
  // hold timer
  // ****************
  fkl_pkg::fkl_state_t state_reg;
  logic [26:0] hold_cnt_reg;
  logic is_reset_action, fire;
  logic [26:0] need_cyc;
  // the reset path of the toggle only counts while running is set
  assign is_reset_action = setting_reg == fkl_pkg::FKL_RST ||
    (setting_reg == fkl_pkg::FKL_RUN_RST && run_state);
  assign need_cyc = is_reset_action ? 27'(HOLD_RST_CYC) :
                    27'(HOLD_RUN_CYC);
  assign fire = state_reg == fkl_pkg::FKL_TIMING && key_reg &&
                hold_cnt_reg >= need_cyc - 27'h1;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= fkl_pkg::FKL_IDLE;
      hold_cnt_reg <= 27'h0;
    end else begin
      case (state_reg)
        fkl_pkg::FKL_IDLE: begin
          hold_cnt_reg <= 27'h0;
          if (key_reg && !protect_reg &&
              setting_reg != fkl_pkg::FKL_OFF) begin
            state_reg <= fkl_pkg::FKL_TIMING;
          end
        end
        fkl_pkg::FKL_TIMING: begin
          if (!key_reg || protect_reg) begin
            state_reg <= fkl_pkg::FKL_IDLE;
          end else if (fire) begin
            state_reg <= fkl_pkg::FKL_WAIT_REL;
          end else begin
            hold_cnt_reg <= hold_cnt_reg + 27'h1;
          end
        end
        fkl_pkg::FKL_WAIT_REL: begin
          // one action per press, however long the hold
          if (!key_reg) begin
            state_reg <= fkl_pkg::FKL_IDLE;
          end
        end
        default: state_reg <= fkl_pkg::FKL_IDLE;
      endcase
    end
  end
  // ****************
  // action dispatch
  // ****************
  function automatic logic is_set(input logic [3:0] s,
                                  input fkl_pkg::fkl_setting_t v);
    is_set = s == 4'(v);
  endfunction : is_set
  logic release_key, at_any, part_inert;
  assign release_key = fire && is_set(setting_reg, fkl_pkg::FKL_ALM_REL);
  assign at_any = autotune_full | autotune_partial;
  assign part_inert = heat_cool_reg | floating_ctrl;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_pulse <= 1'b0;
      reset_pulse <= 1'b0;
      step_forward_pulse <= 1'b0;
    end else begin
      run_pulse <= fire && (is_set(setting_reg, fkl_pkg::FKL_RUN) ||
        (is_set(setting_reg, fkl_pkg::FKL_RUN_RST) && !run_state));
      reset_pulse <= fire && is_reset_action;
      step_forward_pulse <= fire &&
        is_set(setting_reg, fkl_pkg::FKL_STEP);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_state <= 1'b0;
    end else if (fire && is_set(setting_reg, fkl_pkg::FKL_RUN)) begin
      run_state <= 1'b1;
    end else if (fire && is_reset_action) begin
      run_state <= 1'b0;
    end else if (fire && is_set(setting_reg, fkl_pkg::FKL_RUN_RST)) begin
      run_state <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_state <= 1'b0;
    end else if (fire && is_set(setting_reg, fkl_pkg::FKL_HOLD)) begin
      hold_state <= !hold_state;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      autotune_full <= 1'b0;
      autotune_partial <= 1'b0;
    end else if (fire && (is_set(setting_reg, fkl_pkg::FKL_AT_FULL) ||
                 is_set(setting_reg, fkl_pkg::FKL_AT_PART))) begin
      if (at_any) begin
        autotune_full <= 1'b0;
        autotune_partial <= 1'b0;
      end else if (is_set(setting_reg, fkl_pkg::FKL_AT_FULL)) begin
        autotune_full <= 1'b1;
      end else if (!part_inert) begin
        autotune_partial <= 1'b1;
      end
    end
  end
  // cooling coefficient is computed only by heat/cool autotune
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cool_coef_calc <= 1'b0;
    end else begin
      cool_coef_calc <= cool_adj_reg && heat_cool_reg && at_any;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auto_manual <= 1'b0;
    end else if (fire && is_set(setting_reg, fkl_pkg::FKL_AUTO_MAN)) begin
      auto_manual <= !auto_manual;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      item_sel <= 3'h0;
    end else if (fire && is_set(setting_reg, fkl_pkg::FKL_ITEM)) begin
      item_sel <= (item_sel == fkl_pkg::ITEM_COUNT - 3'h1) ? 3'h0 :
                  item_sel + 3'h1;
    end
  end
  // ****************
  // alarm latches
  // ****************
  logic [4:0] alm_in;
  logic [4:0] alm_reg;
  assign alm_in = {heater_short_alarm_raw, burnout_raw, alarm_raw};
  // a new alarm wins over a release in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_alm
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          alm_reg[gi] <= 1'b0;
        end else if (alm_in[gi]) begin
          alm_reg[gi] <= 1'b1;
        end else if (release_key) begin
          alm_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  assign alarm_out = alm_reg[2:0];
  assign burnout_out = alm_reg[3];
  assign heater_short_alarm_out = alm_reg[4];
  // ****************
  // heater overcurrent
  // ****************
  logic oc_reg;
  logic [10:0] off_level;
  assign off_level = {1'b0, thr_reg} - {1'b0, hyst_reg};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oc_reg <= 1'b0;
    end else if (!oc_use_reg || setup_level) begin
      oc_reg <= 1'b0;
    end else if (latch_en_reg) begin
      if (oc_raw && thr_reg != fkl_pkg::OC_THR_MAX) begin
        oc_reg <= 1'b1;
      end else if (thr_reg == fkl_pkg::OC_THR_MAX || release_key ||
                   event_release) begin
        oc_reg <= 1'b0;
      end
    end else if (oc_raw) begin
      oc_reg <= 1'b1;
    end else if ({1'b0, oc_current} < off_level || off_level[10]) begin
      oc_reg <= 1'b0;
    end
  end
  assign oc_out = oc_reg;
  // ****************
  // register read
  // ****************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        fkl_pkg::ADDR_CFG: rdata <= {7'h00, heat_cool_reg, cool_adj_reg,
          oc_use_reg, latch_en_reg, protect_reg, setting_reg};
        fkl_pkg::ADDR_HYST: rdata <= {6'h00, hyst_reg};
        fkl_pkg::ADDR_THR: rdata <= {6'h00, thr_reg};
        fkl_pkg::ADDR_STAT: rdata <= {1'b0, item_sel, oc_reg, alm_reg,
          auto_manual, autotune_partial, autotune_full, hold_state,
          run_state, key_reg};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule : fkl_function_key

// ### fkl_function_key_sva.sv
`timescale 1ns/100ps
module fkl_function_key_sva #(
  parameter int HOLD_RUN_CYC = 20,
  parameter int HOLD_RST_CYC = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic function_key,
  input wire logic front_key_a,
  input wire logic front_key_b,
  input wire logic has_function_key,
  input wire logic [2:0] alarm_raw,
  input wire logic run_pulse,
  input wire logic reset_pulse,
  input wire logic hold_state,
  input wire logic step_forward_pulse,
  input wire logic autotune_full,
  input wire logic autotune_partial,
  input wire logic auto_manual,
  input wire logic [2:0] item_sel,
  input wire logic [2:0] alarm_out
);
  logic key_in;
  logic key_q;
  int press_len;
  assign key_in = has_function_key ? function_key : front_key_a & front_key_b;
  // length of the latest press, kept after release since actions land late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_q <= 1'b0;
      press_len <= 0;
    end else begin
      key_q <= key_in;
      if (key_in && !key_q) press_len <= 1;
      else if (key_in) press_len <= press_len + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_run_held: assert property (run_pulse |->
    press_len >= HOLD_RUN_CYC - 2)
    else $error("run after short press");
  a_reset_held: assert property (reset_pulse |->
    press_len >= HOLD_RST_CYC - 2)
    else $error("reset after short press");
  a_run_once: assert property (run_pulse |=> !run_pulse)
    else $error("run pulse too long");
  a_step_once: assert property (step_forward_pulse |=>
    !step_forward_pulse)
    else $error("step pulse too long");
  a_pulse_excl: assert property (!(run_pulse && reset_pulse))
    else $error("run and reset together");
  a_state_held: assert property (($changed(hold_state) ||
    $changed(auto_manual)) |-> press_len >= HOLD_RUN_CYC - 2)
    else $error("toggle after short press");
  a_item_step: assert property ($changed(item_sel) |-> item_sel ==
    (($past(item_sel) == 3'h4) ? 3'h0 : $past(item_sel) + 3'h1))
    else $error("item skipped");
  a_item_range: assert property (item_sel <= 3'h4)
    else $error("item out of range");
  a_at_excl: assert property (!(autotune_full && autotune_partial))
    else $error("two autotunes at once");
  a_alarm_set: assert property (1'b1 |=>
    (alarm_out & $past(alarm_raw)) == $past(alarm_raw))
    else $error("alarm not latched");
endmodule : fkl_function_key_sva
bind fkl_function_key fkl_function_key_sva #(
  .HOLD_RUN_CYC(HOLD_RUN_CYC), .HOLD_RST_CYC(HOLD_RST_CYC)
) fkl_function_key_sva_inst (.clk, .rst_n, .function_key, .front_key_a,
  .front_key_b, .has_function_key, .alarm_raw, .run_pulse, .reset_pulse,
  .hold_state, .step_forward_pulse, .autotune_full, .autotune_partial,
  .auto_manual, .item_sel, .alarm_out);

// ### fkl_operator.sv
`timescale 1ns/100ps
module fkl_operator (
  output logic function_key,
  output logic front_key_a,
  output logic front_key_b,
  input wire logic clk
);
  initial begin
    function_key = 1'b0;
    front_key_a = 1'b0;
    front_key_b = 1'b0;
  end
  // a press is one clean level; contact bounce is not modelled
  task automatic press(input int len, input logic pair);
    @(posedge clk);
    if (pair) begin
      front_key_a <= 1'b1;
      front_key_b <= 1'b1;
    end else begin
      function_key <= 1'b1;
    end
    repeat (len) @(posedge clk);
    function_key <= 1'b0;
    front_key_a <= 1'b0;
    front_key_b <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : press
endmodule : fkl_operator

// ### fkl_function_key_bench.sv
`timescale 1ns/100ps
module fkl_function_key_bench;
  localparam int RUN = 20;
  localparam int RST = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic has_function_key = 1'b1;
  logic floating_ctrl = 1'b0;
  logic oc_raw = 1'b0;
  logic burnout_raw = 1'b0;
  logic heater_short_alarm_raw = 1'b0;
  logic event_release = 1'b0;
  logic setup_level = 1'b0;
  logic [2:0] alarm_raw = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [9:0] oc_current = 10'h000;
  logic [15:0] wdata = 16'h0;
  logic function_key, front_key_a, front_key_b, run_pulse, reset_pulse;
  logic run_state, hold_state, step_forward_pulse, autotune_full;
  logic autotune_partial, auto_manual, cool_coef_calc, burnout_out;
  logic heater_short_alarm_out, oc_out;
  logic [2:0] item_sel, alarm_out, ai, ea;
  logic [5:0] lat;
  logic [15:0] rdata, d;
  int checks = 0;
  int mismatches = 0;
  int steps = 0;
  int runs = 0;
  int resets = 0;
  int seed = 3931;
  int i;
  assign lat = {alarm_out, burnout_out, heater_short_alarm_out, oc_out};
  fkl_operator fkl_operator_inst (.clk, .function_key, .front_key_a,
    .front_key_b);
  fkl_function_key #(.HOLD_RUN_CYC(RUN), .HOLD_RST_CYC(RST))
    fkl_function_key_inst (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .function_key, .front_key_a, .front_key_b, .has_function_key,
    .floating_ctrl, .oc_raw, .alarm_raw, .burnout_raw,
    .heater_short_alarm_raw, .event_release, .setup_level, .oc_current,
    .run_pulse, .reset_pulse, .run_state, .hold_state, .step_forward_pulse,
    .autotune_full, .autotune_partial, .auto_manual, .item_sel,
    .cool_coef_calc, .alarm_out, .burnout_out, .heater_short_alarm_out,
    .oc_out);
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (step_forward_pulse === 1'b1) steps <= steps + 1;
    if (run_pulse === 1'b1) runs <= runs + 1;
    if (reset_pulse === 1'b1) resets <= resets + 1;
  end
  // ****
  // tasks
  // ****
  function automatic logic [15:0] cfg(input logic [3:0] s);
    return {12'h004, s};
  endfunction : cfg
  function automatic logic [2:0] next_item(input logic [2:0] v);
    return (v == 3'h4) ? 3'h0 : v + 3'h1;
  endfunction : next_item
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic c1(input logic seen, input logic exp);
    chk({15'h0, seen}, {15'h0, exp});
  endtask : c1
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic bus(input logic wn, input logic [3:0] a,
    input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= wn;
    rd <= !wn;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus
  task automatic p(input int n);
    fkl_operator_inst.press(n, 1'b0);
    #1;
  endtask : p
  task automatic ocp();
    @(posedge clk);
    oc_raw <= 1'b1;
    @(posedge clk);
    oc_raw <= 1'b0;
    w(3);
  endtask : ocp
  initial begin
    w(30000);
    mismatches++;
    summarize();
  end
  // ****
  // scenarios
  // ****
  initial begin
    w(8);
    rst_n <= 1'b1;
    bus(1'b0, fkl_pkg::ADDR_CFG, 16'h0);
    chk(d & 16'h000f, 16'h0003);
    chk(d & 16'h00e0, 16'h0040);
    bus(1'b1, fkl_pkg::ADDR_HYST, 16'h0);
    bus(1'b1, fkl_pkg::ADDR_HYST, 16'h01f5);
    bus(1'b0, fkl_pkg::ADDR_HYST, 16'h0);
    chk(d, 16'h0001);
    bus(1'b0, 4'hf, 16'h0);
    chk(d, 16'h0);
    p(RUN + 6);
    c1(run_state, 1'b1);
    p(RST - 6);
    c1(run_state, 1'b1);
    p(RST + 6);
    c1(run_state, 1'b0);
    p(RUN - 6);
    c1(run_state, 1'b0);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h3) | 16'h0010);
    p(RUN + 6);
    c1(run_state, 1'b0);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h0));
    p(RUN + 6);
    c1(run_state, 1'b0);
    chk(16'(runs), 16'h0001);
    chk(16'(resets), 16'h0001);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h1));
    p(RUN + 6);
    c1(run_state, 1'b1);
    chk(16'(runs), 16'h0002);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h2));
    p(RST - 6);
    chk(16'(resets), 16'h0001);
    p(RST + 6);
    c1(run_state, 1'b0);
    chk(16'(resets), 16'h0002);
    $display("run_reset done");
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h4));
    for (i = 0; i < 2; i++) begin
      p(RUN + 6);
      c1(hold_state, i == 0);
    end
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h5));
    p(RUN + 6);
    chk(16'(steps), 16'h0001);
    has_function_key <= 1'b0;
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h9));
    p(RUN + 6);
    c1(auto_manual, 1'b0);
    fkl_operator_inst.press(RUN + 6, 1'b1);
    #1;
    c1(auto_manual, 1'b1);
    has_function_key <= 1'b1;
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h6) | 16'h0180);
    p(RUN + 6);
    c1(autotune_full, 1'b1);
    c1(cool_coef_calc, 1'b1);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h7));
    p(RUN + 6);
    c1(autotune_full, 1'b0);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h7) | 16'h0100);
    p(RUN + 6);
    c1(autotune_partial, 1'b0);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h7));
    floating_ctrl <= 1'b1;
    p(RUN + 6);
    c1(autotune_partial, 1'b0);
    floating_ctrl <= 1'b0;
    p(RUN + 6);
    c1(autotune_partial, 1'b1);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h6));
    p(RUN + 6);
    c1(autotune_partial, 1'b0);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'ha));
    ea = 3'h0;
    for (i = 0; i < 6; i++) begin
      p(RUN + 4 + ($random(seed) & 7));
      ea = next_item(ea);
      chk({13'h0, item_sel}, {13'h0, ea});
    end
    $display("modes done");
    ai = 3'($random(seed)) | 3'h1;
    alarm_raw <= ai;
    burnout_raw <= 1'b1;
    heater_short_alarm_raw <= 1'b1;
    w(1);
    alarm_raw <= 3'h0;
    burnout_raw <= 1'b0;
    heater_short_alarm_raw <= 1'b0;
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h8) | 16'h0020);
    bus(1'b1, fkl_pkg::ADDR_THR, 16'h0064);
    ocp();
    w(20);
    chk({10'h0, lat}, {10'h0, ai, 3'h7});
    p(RUN + 6);
    chk({10'h0, lat}, 16'h0);
    ocp();
    setup_level <= 1'b1;
    w(2);
    c1(oc_out, 1'b0);
    setup_level <= 1'b0;
    ocp();
    event_release <= 1'b1;
    w(2);
    event_release <= 1'b0;
    c1(oc_out, 1'b0);
    ocp();
    bus(1'b1, fkl_pkg::ADDR_THR, 16'h01f4);
    w(2);
    c1(oc_out, 1'b0);
    bus(1'b1, fkl_pkg::ADDR_CFG, cfg(4'h8));
    bus(1'b1, fkl_pkg::ADDR_THR, 16'h0064);
    bus(1'b1, fkl_pkg::ADDR_HYST, 16'h000a);
    oc_current <= 10'h05f;
    ocp();
    c1(oc_out, 1'b1);
    oc_current <= 10'h059;
    w(3);
    c1(oc_out, 1'b0);
    $display("alarms done");
    summarize();
  end
endmodule : fkl_function_key_bench
